//--- core/ddr_ctl_end.sv
`timescale 1ns/10ps
module ddr_ctl_end import ddr_lvl_pkg::*; #(
   parameter int DLL_LOCK_CYCLES = DLL_LOCK_CYC,
   parameter int CK_DIV = 4
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   ddr_lvl_if.ctl bus,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_fast_clock
);
   // Below four mclk per link clock the synchronised edge arrives after the command is gone
   if (CK_DIV < 4 || CK_DIV > 256 || CK_DIV % 2 != 0) begin : g_bad_div
      $error("CK_DIV must be even and between 4 and 256");
   end
   if (DLL_LOCK_CYCLES < 1 || DLL_LOCK_CYCLES >= (1 << CNT_W)) begin : g_bad_lock
      $error("DLL_LOCK_CYCLES out of range");
   end
   typedef enum logic [4:0] {
      ST_IDLE = 5'h00, ST_OFF_MRS = 5'h01, ST_OFF_MOD = 5'h02, ST_OFF_SRE = 5'h03,
      ST_OFF_HOLD = 5'h04, ST_OFF_SETUP = 5'h05, ST_OFF_SRX = 5'h06, ST_OFF_XS = 5'h07,
      ST_OFF_REWRITE = 5'h08, ST_OFF_FIN = 5'h09,
      ST_ON_SRE = 5'h0A, ST_ON_HOLD = 5'h0B, ST_ON_SETUP = 5'h0C, ST_ON_SRX = 5'h0D,
      ST_ON_XS = 5'h0E, ST_ON_EN = 5'h0F, ST_ON_MRD1 = 5'h10, ST_ON_RST = 5'h11,
      ST_ON_MRD2 = 5'h12, ST_ON_LOCK = 5'h13,
      ST_LV_MRS = 5'h14, ST_LV_MOD = 5'h15, ST_LV_PULSE = 5'h16, ST_LV_LOW = 5'h17,
      ST_LV_WAIT = 5'h18, ST_LV_EXIT = 5'h19, ST_LV_FIN = 5'h1A
   } state_t;
   state_t st_q;
   logic [CNT_W-1:0] cnt_q;
   logic [7:0] div_q;
   logic ck_q, ck_rise;
   logic [15:0] fb_s;
   logic [16:0] fb_sync;
   logic fb_oe_n_s, fb_bit;
   logic [7:0] delay_q;
   logic locked_q, out_off_q, fail_q, fb_prev_q;
   logic cmd_go;
   cmd_t cmd_q;
   logic [1:0] sel_q;
   logic [ADDR_W-1:0] addr_q;
   logic cke_q, odt_q, dqs_q;
   sync2 #(.W(17)) u_fb (.i_mclk(i_mclk), .i_rst(i_rst), .i_d({bus.dq_oe_n, bus.dq_out}), .o_q(fb_sync));
   assign fb_s = fb_sync[15:0];
   assign fb_oe_n_s = fb_sync[16];
   // A rank with its buffers off gives no feedback, whatever its pins still hold
   assign fb_bit = fb_s[0] && !fb_oe_n_s;
   // ****************************************
   // Link clock divider; slowed while DLL is off
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         div_q <= 8'h00;
         ck_q <= 1'b0;
      end else if (div_q >= 8'(((o_fast_clock ? CK_DIV : 2 * CK_DIV) / 2) - 1)) begin
         div_q <= 8'h00;
         ck_q <= !ck_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
   // Rate only switches in self-refresh; a count past the new limit wraps at once instead of stalling
   // Power-down rate changes are never used, so their hold rules are kept trivially
   assign ck_rise = (div_q == 8'h00) && !ck_q;
   assign cmd_go = ck_rise;
   assign bus.ck = ck_q;
   assign bus.cke = cke_q;
   assign bus.termination_control_pin = odt_q;
   assign bus.cmd = cmd_q;
   assign bus.sel = sel_q;
   assign bus.addr = addr_q;
   assign bus.dqs = {2{dqs_q}};
   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         cmd_q <= CMD_DES;
         sel_q <= SEL_BASE;
         addr_q <= '0;
         cke_q <= 1'b1;
         odt_q <= 1'b0;
         dqs_q <= 1'b0;
         o_fast_clock <= 1'b1;
         delay_q <= 8'h00;
         locked_q <= 1'b0;
         fail_q <= 1'b0;
         fb_prev_q <= 1'b0;
         out_off_q <= 1'b0;
      end else begin
         if (cmd_go) cmd_q <= CMD_NOP;
         if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
         case (st_q)
            ST_IDLE: begin
               // Odt stays low at idle so termination is off
               odt_q <= 1'b0;
               if (i_wr && i_addr == REG_CTRL) begin
                  out_off_q <= i_wdata[CTRL_OUTPUT_OFF];
                  if (i_wdata[CTRL_GO_DLL_OFF] && o_fast_clock) st_q <= ST_OFF_MRS;
                  else if (i_wdata[CTRL_GO_DLL_ON] && !o_fast_clock) st_q <= ST_ON_SRE;
                  else if (i_wdata[CTRL_GO_LEVEL]) begin
                     st_q <= ST_LV_MRS;
                     delay_q <= 8'h00;
                     locked_q <= 1'b0;
                     fail_q <= 1'b0;
                     fb_prev_q <= 1'b1;
                  end
               end
            end
            ST_OFF_MRS: if (cmd_go) begin
               cmd_q <= CMD_MRS; sel_q <= SEL_EXT;
               addr_q <= 16'h0001 << DLL_DISABLE_POS;
               cnt_q <= CNT_W'(MODE_UPDATE_CYC); st_q <= ST_OFF_MOD;
            end
            ST_OFF_MOD, ST_ON_SRE: if (cnt_q == '0 && cmd_go) begin
               cmd_q <= CMD_SRE; cke_q <= 1'b0;
               cnt_q <= CNT_W'(ENTRY_HOLD_CYC);
               st_q <= (st_q == ST_OFF_MOD) ? ST_OFF_HOLD : ST_ON_HOLD;
            end
            ST_OFF_HOLD, ST_ON_HOLD: if (cnt_q == '0) begin
               o_fast_clock <= (st_q == ST_ON_HOLD);
               cnt_q <= CNT_W'(EXIT_SETUP_CYC);
               st_q <= (st_q == ST_OFF_HOLD) ? ST_OFF_SETUP : ST_ON_SETUP;
            end
            ST_OFF_SETUP, ST_ON_SETUP: if (cnt_q == '0 && cmd_go) begin
               cmd_q <= CMD_SRX; cke_q <= 1'b1; odt_q <= 1'b0;
               cnt_q <= CNT_W'(SR_EXIT_CYC);
               st_q <= (st_q == ST_OFF_SETUP) ? ST_OFF_XS : ST_ON_XS;
            end
            ST_OFF_XS: if (cnt_q == '0 && cmd_go) begin
               cmd_q <= CMD_MRS; sel_q <= SEL_BASE; addr_q <= '0;
               cnt_q <= CNT_W'(MODE_UPDATE_CYC); st_q <= ST_OFF_FIN;
            end
            ST_OFF_FIN, ST_ON_LOCK, ST_LV_FIN: if (cnt_q == '0) st_q <= ST_IDLE;
            ST_ON_XS: if (cnt_q == '0 && cmd_go) begin
               cmd_q <= CMD_MRS; sel_q <= SEL_EXT; addr_q <= '0;
               cnt_q <= CNT_W'(MODE_CMD_CYC); st_q <= ST_ON_MRD1;
            end
            ST_ON_MRD1: if (cnt_q == '0 && cmd_go) begin
               cmd_q <= CMD_MRS; sel_q <= SEL_BASE;
               addr_q <= 16'h0001 << DLL_RESET_POS;
               cnt_q <= CNT_W'(MODE_CMD_CYC); st_q <= ST_ON_MRD2;
            end
            ST_ON_MRD2: if (cnt_q == '0 && cmd_go) begin
               cmd_q <= CMD_MRS; sel_q <= SEL_BASE; addr_q <= '0;
               cnt_q <= CNT_W'(DLL_LOCK_CYCLES); st_q <= ST_ON_LOCK;
            end
            ST_LV_MRS: if (cmd_go) begin
               // Outputs enabled would limit termination; none is programmed here
               cmd_q <= CMD_MRS; sel_q <= SEL_EXT;
               addr_q <= (16'h0001 << LEVELING_ENABLE_POS) | (16'(out_off_q) << OUTPUT_OFF_POS)
                  | (16'(!o_fast_clock) << DLL_DISABLE_POS);
               cnt_q <= CNT_W'(MODE_UPDATE_CYC); st_q <= ST_LV_MOD;
            end
            ST_LV_MOD: if (cnt_q == '0) begin
               odt_q <= 1'b1;
               cnt_q <= CNT_W'({4'h0, delay_q}) + CNT_W'(CK_DIV); st_q <= ST_LV_PULSE;
            end
            ST_LV_PULSE: if (cnt_q == '0) begin
               dqs_q <= 1'b1; cnt_q <= CNT_W'(CK_DIV); st_q <= ST_LV_LOW;
            end
            ST_LV_LOW: if (cnt_q == '0) begin
               dqs_q <= 1'b0; cnt_q <= CNT_W'(CK_DIV); st_q <= ST_LV_WAIT;
            end
            ST_LV_WAIT: if (cnt_q == '0) begin
               // Lower lane decides; a 0 then 1 locks the setting
               fb_prev_q <= fb_bit;
               if (!fb_prev_q && fb_bit) begin
                  locked_q <= 1'b1; st_q <= ST_LV_EXIT;
               end else if (delay_q == 8'(MAX_DELAY)) begin
                  fail_q <= 1'b1; st_q <= ST_LV_EXIT;
               end else begin
                  delay_q <= delay_q + 8'h01;
                  cnt_q <= CNT_W'({4'h0, delay_q}) + CNT_W'(CK_DIV); st_q <= ST_LV_PULSE;
               end
            end
            ST_LV_EXIT: begin
               odt_q <= 1'b0;
               if (cmd_go) begin
                  cmd_q <= CMD_MRS; sel_q <= SEL_EXT; addr_q <= 16'(!o_fast_clock) << DLL_DISABLE_POS;
                  cnt_q <= CNT_W'(MODE_UPDATE_CYC); st_q <= ST_LV_FIN;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   // ****************************************
   // Register read port
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) o_rdata <= 32'h0000_0000;
      else if (i_rd) begin
         case (i_addr)
            REG_STATUS: o_rdata <= {24'h0, fail_q, locked_q, !o_fast_clock, st_q == ST_IDLE, fb_s[8], fb_s[0], 2'h0};
            REG_DELAY: o_rdata <= {24'h0, delay_q};
            REG_CTRL: o_rdata <= {27'h0, out_off_q, 4'h0};
            default: o_rdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

//--- core/ddr_mem_end.sv
`timescale 1ns/10ps
module ddr_mem_end import ddr_lvl_pkg::*; (
   input wire logic i_mclk,
   input wire logic i_rst,
   ddr_lvl_if.mem bus,
   output logic o_dll_on,
   output logic o_leveling,
   output logic o_outputs_off,
   output logic o_self_refresh,
   output logic o_dqs_term_on,
   output logic o_dq_term_on
);
   logic [4:0] s_q;
   logic ck_s, cke_s, odt_s;
   logic [1:0] dqs_s;
   logic [ADDR_W-1:0] ext_q;
   logic ck_last_q;
   logic [1:0] dqs_last_q;
   logic [15:0] fb_q;
   logic cmd_edge;
   sync2 #(.W(5)) u_sync (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_d({bus.ck, bus.cke, bus.termination_control_pin, bus.dqs}), .o_q(s_q));
   assign {ck_s, cke_s, odt_s, dqs_s} = s_q;
   assign cmd_edge = ck_s && !ck_last_q;
   // ****************************************
   // Extended mode register and self-refresh
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ext_q <= EXT_RESET;
         o_self_refresh <= 1'b0;
         ck_last_q <= 1'b0;
      end else begin
         ck_last_q <= ck_s;
         // Mode register commands in self-refresh are ignored; exit needs cke
         if (cmd_edge && !o_self_refresh && bus.cmd == CMD_MRS && bus.sel == SEL_EXT)
            ext_q <= bus.addr;
         if (cmd_edge && bus.cmd == CMD_SRE)
            o_self_refresh <= 1'b1;
         else if (o_self_refresh && cke_s)
            o_self_refresh <= 1'b0;
      end
   end
   assign o_dll_on = !ext_q[DLL_DISABLE_POS];
   assign o_leveling = ext_q[LEVELING_ENABLE_POS];
   assign o_outputs_off = ext_q[OUTPUT_OFF_POS];
   assign o_dqs_term_on = o_leveling && odt_s;
   assign o_dq_term_on = 1'b0;
   // ****************************************
   // Leveling feedback, per byte lane
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         dqs_last_q <= 2'h0;
         fb_q <= 16'h0000;
      end else begin
         dqs_last_q <= dqs_s;
         if (o_leveling && dqs_s[0] && !dqs_last_q[0])
            fb_q[7:0] <= {8{ck_s}};
         if (o_leveling && dqs_s[1] && !dqs_last_q[1])
            fb_q[15:8] <= {8{ck_s}};
      end
   end
   assign bus.dq_out = fb_q;
   assign bus.dq_oe_n = !(o_leveling && !o_outputs_off);
endmodule

//--- core/sync2.sv
`timescale 1ns/10ps
module sync2 #(parameter int W = 1) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   // Only the second stage may be read by logic
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= '0;
         o_q <= '0;
      end else begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule

//--- dv/ddr_lvl_asserts.sv
`timescale 1ns/10ps
module ddr_lvl_asserts import ddr_lvl_pkg::*; (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic ck,
   input wire logic cke,
   input wire logic termination_control_pin,
   input wire cmd_t cmd,
   input wire logic [1:0] sel,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [1:0] dqs,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe_n
);
   // ****************************************
   // Link checks
   // ****************************************
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // Phase lengths of the link clock; a rate change is only legal with clock enable low
   logic ck_d_q;
   logic [7:0] ph_len_q, ph_last_q;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ck_d_q <= 1'b0;
         ph_len_q <= 8'h00;
         ph_last_q <= 8'h00;
      end else begin
         ck_d_q <= ck;
         if (ck != ck_d_q) begin
            ph_last_q <= ph_len_q;
            ph_len_q <= 8'h01;
         end else if (ph_len_q != 8'hFF) begin
            ph_len_q <= ph_len_q + 8'h01;
         end
      end
   end
   a_lane_equal: assert property (!dq_oe_n |-> (dq_out[7:0] == 8'h00 || dq_out[7:0] == 8'hFF) &&
      (dq_out[15:8] == 8'h00 || dq_out[15:8] == 8'hFF)) else $error("lane bits differ");
   a_lvl_cmds: assert property (termination_control_pin |-> (cmd == CMD_NOP || cmd == CMD_DES))
      else $error("command while leveling");
   a_odt_low_sr: assert property (!cke |-> !termination_control_pin) else $error("termination on while clock enable low");
   a_sr_hold: assert property ($fell(cke) |-> !cke [*8]) else $error("self refresh left too soon");
   a_srx_cke: assert property ($rose(cke) |-> cke [*8]) else $error("clock enable dropped after exit");
   a_exit_quiet: assert property ($rose(cke) |-> (cmd != CMD_MRS) [*8])
      else $error("mode command inside exit delay");
   a_dqs_in_lvl: assert property (dqs != 2'h0 |-> termination_control_pin) else $error("strobe outside leveling");
   a_dqs_quiet_sr: assert property (!cke |-> dqs == 2'h0) else $error("strobe during self refresh");
   a_ck_rate_steady: assert property ((ck != ck_d_q) && cke && $past(cke) && ph_last_q != 8'h00 |->
      ph_len_q == ph_last_q) else $error("link clock rate changed with clock enable high");
   a_lvl_exit_mrs: assert property ($fell(termination_control_pin) |-> ##[0:8]
      (cmd == CMD_MRS && sel == SEL_EXT && !addr[LEVELING_ENABLE_POS])) else $error("leveling not ended");
   // Reach checks only
   c_exit: cover property ($rose(cke));
   c_level: cover property ($rose(termination_control_pin));
   c_fb_high: cover property (!dq_oe_n && dq_out[0]);
endmodule

//--- dv/dll_switch_freq_change_write_leveling_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module dll_switch_freq_change_write_leveling_tb import ddr_lvl_pkg::*;;
   // ****************************************
   // Harness
   // ****************************************
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic fast_clock, dll_on, leveling, outputs_off, self_refresh, dqs_term_on, dq_term_on;
   logic saw_sr, saw_lvl, saw_rst, saw_dqs_term, bad_term, saw_off_drive;
   int fail_count = 0;
   int n_tests = 0;
   ddr_lvl_if bus();
   always #12.5 i_mclk = ~i_mclk;
   ddr_ctl_end #(.DLL_LOCK_CYCLES(8), .CK_DIV(4)) ddr_ctl_end_i (.i_mclk(i_mclk), .i_rst(i_rst), .bus(bus.ctl),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fast_clock(fast_clock));
   ddr_mem_end ddr_mem_end_i (.i_mclk(i_mclk), .i_rst(i_rst), .bus(bus.mem), .o_dll_on(dll_on),
      .o_leveling(leveling), .o_outputs_off(outputs_off), .o_self_refresh(self_refresh),
      .o_dqs_term_on(dqs_term_on), .o_dq_term_on(dq_term_on));
   ddr_lvl_asserts ddr_lvl_asserts_i (.i_mclk(i_mclk), .i_rst(i_rst), .ck(bus.ck), .cke(bus.cke), .termination_control_pin(bus.termination_control_pin),
      .cmd(bus.cmd), .sel(bus.sel), .addr(bus.addr), .dqs(bus.dqs), .dq_out(bus.dq_out), .dq_oe_n(bus.dq_oe_n));
   // Sticky flags, so short events between register polls are not missed
   always @(posedge i_mclk) begin
      if (self_refresh === 1'b1) saw_sr <= 1'b1;
      if (leveling === 1'b1) saw_lvl <= 1'b1;
      if (dqs_term_on === 1'b1) saw_dqs_term <= 1'b1;
      if (dq_term_on !== 1'b0 || (dqs_term_on === 1'b1 && leveling !== 1'b1)) bad_term <= 1'b1;
      if (outputs_off === 1'b1 && bus.dq_oe_n === 1'b0) saw_off_drive <= 1'b1;
      if (bus.cmd == CMD_MRS && bus.sel == SEL_BASE && bus.addr[DLL_RESET_POS]) saw_rst <= 1'b1;
   end
   // ****************************************
   // Register port tasks
   // ****************************************
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic wait_idle(output logic [31:0] s);
      int n;
      repeat (4) @(posedge i_mclk);
      for (n = 0; n < 30000; n++) begin
         rd(REG_STATUS, s);
         if (s[4] === 1'b1) break;
      end
      if (n == 30000) `CHK(1'b0, 1'b1)
   endtask
   task automatic clear_flags();
      @(posedge i_mclk);
      {saw_sr, saw_lvl, saw_rst, saw_dqs_term, bad_term, saw_off_drive} <= 6'h00;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      logic [31:0] s;
      `CHK(dll_on, 1'b1)
      `CHK(leveling, 1'b0)
      `CHK(fast_clock, 1'b1)
      rd(REG_STATUS, s);
      `CHK(s[5:4], 2'h1)
      rd(4'hF, s);
      `CHK(s, 32'h0)
   endtask
   task automatic t_dll_off();
      logic [31:0] s;
      clear_flags();
      wr(REG_CTRL, 32'h1);
      wr(REG_CTRL, 32'h4); // Refused while busy
      wait_idle(s);
      `CHK(dll_on, 1'b0)
      `CHK(fast_clock, 1'b0)
      `CHK(saw_sr, 1'b1)
      `CHK(saw_lvl, 1'b0)
      `CHK(s[5], 1'b1)
      wr(REG_CTRL, 32'h1); // Already off, so ignored
      wait_idle(s);
      `CHK(dll_on, 1'b0)
   endtask
   task automatic t_dll_on();
      logic [31:0] s;
      clear_flags();
      wr(REG_CTRL, 32'h2);
      wait_idle(s);
      `CHK(dll_on, 1'b1)
      `CHK(saw_rst, 1'b1)
      `CHK(saw_sr, 1'b1)
      `CHK(fast_clock, 1'b1)
      `CHK(s[6:5], 2'h2)
   endtask
   task automatic t_level(input logic off);
      logic [31:0] s;
      logic dll_was;
      dll_was = dll_on;
      clear_flags();
      wr(REG_CTRL, {27'h0, off, 4'h4});
      wait_idle(s);
      `CHK(saw_lvl, 1'b1)
      `CHK(leveling, 1'b0)
      `CHK(saw_dqs_term, 1'b1)
      `CHK(bad_term, 1'b0)
      `CHK(saw_off_drive, 1'b0)
      if (!off) begin
         `CHK(s[3:2], 2'h3)
         `CHK(s[7], 1'b0)
      end else begin
         `CHK(s[7:6], 2'h2)
      end
      `CHK(dll_on, dll_was)
   endtask
   // ****************************************
   // Main sequence and verdict
   // ****************************************
   task automatic end_sim();
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      t_reset();
      t_level(1'b0);
      t_dll_off();
      t_level(1'b0);
      t_dll_on();
      t_level(1'b1);
      t_level(1'b0);
      end_sim();
   end
   // Sweeps can run the full delay range, so the limit is generous
   initial begin
      repeat (100000) @(posedge i_mclk);
      fail_count++;
      end_sim();
   end
endmodule

//--- shared/ddr_lvl_if.sv
`timescale 1ns/10ps
interface ddr_lvl_if;
   import ddr_lvl_pkg::*;
   logic ck;
   logic cke;
   logic termination_control_pin;
   cmd_t cmd;
   logic [1:0] sel;
   logic [ADDR_W-1:0] addr;
   logic [1:0] dqs;
   logic [15:0] dq_out;
   logic dq_oe_n;
   modport mem (input ck, cke, termination_control_pin, cmd, sel, addr, dqs, output dq_out, dq_oe_n);
   modport ctl (output ck, cke, termination_control_pin, cmd, sel, addr, dqs, input dq_out, dq_oe_n);
endinterface

//--- shared/ddr_lvl_pkg.sv
package ddr_lvl_pkg;
   // ****************************************
   // Commands on the link
   // ****************************************
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_MRS = 3'h1,
      CMD_SRE = 3'h2,
      CMD_SRX = 3'h3,
      CMD_PDE = 3'h4,
      CMD_PDX = 3'h5,
      CMD_DES = 3'h7
   } cmd_t;
   // ****************************************
   // Mode register selection and bits
   // ****************************************
   localparam logic [1:0] SEL_BASE = 2'h0;
   localparam logic [1:0] SEL_EXT = 2'h1;
   localparam int ADDR_W = 16;
   localparam int DLL_DISABLE_POS = 0;
   localparam int LEVELING_ENABLE_POS = 7;
   localparam int DLL_RESET_POS = 8;
   localparam int OUTPUT_OFF_POS = 12;
   localparam logic [ADDR_W-1:0] EXT_RESET = 16'h0000;
   // ****************************************
   // Timing, in nanoseconds and derived clock counts
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int MODE_UPDATE_DELAY_NS = 300;
   localparam int MODE_COMMAND_CYCLE_TIME_NS = 100;
   localparam int ENTRY_CLOCK_HOLD_TIME_NS = 250;
   localparam int EXIT_CLOCK_SETUP_TIME_NS = 250;
   localparam int SELF_REFRESH_EXIT_DELAY_NS = 500;
   localparam int DLL_LOCK_TIME_NS = 2000;
   localparam int MODE_UPDATE_CYC = (MODE_UPDATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MODE_CMD_CYC = (MODE_COMMAND_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ENTRY_HOLD_CYC = (ENTRY_CLOCK_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXIT_SETUP_CYC = (EXIT_CLOCK_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SR_EXIT_CYC = (SELF_REFRESH_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DLL_LOCK_CYC = (DLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;
   // ****************************************
   // Controller register map
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_DELAY = 4'h2;
   localparam int CTRL_GO_DLL_OFF = 0;
   localparam int CTRL_GO_DLL_ON = 1;
   localparam int CTRL_GO_LEVEL = 2;
   localparam int CTRL_GO_LEVEL_EXIT = 3;
   localparam int CTRL_OUTPUT_OFF = 4;
   localparam int MAX_DELAY = 255;
endpackage
